//--- dv/asr_ctrl_checker.sv
`timescale 1ns/100ps
module asr_ctrl_checker #(
    parameter int RECOV_CYCLES = 20
) (
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       rstn,
    // Watched outputs
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic                       retained,
    input wire logic [asr_pkg::ADDR_W-1:0] address_lines,
    input wire logic                       cs_n,
    input wire logic                       we_n,
    input wire logic                       oe_n,
    input wire logic [asr_pkg::DATA_W-1:0] shared_data_lines_o,
    input wire logic                       shared_data_lines_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Cycles since retention ended; starts full because reset needs no wait
    logic [23:0] rcv_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) rcv_q <= 24'(RECOV_CYCLES);
        else if (retained) rcv_q <= 24'h0;
        else if (rcv_q < 24'(RECOV_CYCLES)) rcv_q <= rcv_q + 24'h1;
    end
    AST_OE_IN_WRITE: assert property (!we_n |-> oe_n)
        else $error("output enable low during write");
    AST_ADDR_HOLD: assert property ($changed(address_lines) |-> (cs_n || we_n) && ($past(cs_n) || $past(we_n)))
        else $error("address moved inside write window");
    AST_WE_IN_READ: assert property (!oe_n |-> we_n && !shared_data_lines_oe)
        else $error("write enable or data drive during read");
    AST_FLOAT_GAP: assert property ($rose(shared_data_lines_oe) |-> $past(oe_n) && $past(oe_n, 2))
        else $error("data drive too soon after read");
    AST_WRITE_PULSE: assert property ($fell(we_n) |-> (!we_n && !cs_n)[*3] ##1 (we_n && cs_n))
        else $error("write window length wrong");
    AST_WDATA_SETUP: assert property (!we_n |-> shared_data_lines_oe && ($past(we_n) || $stable(shared_data_lines_o)))
        else $error("write data not held in window");
    AST_CYCLE_GAP: assert property ($rose(cs_n) |-> cs_n[*3])
        else $error("accesses too close");
    AST_RETAIN_DESELECT: assert property (retained |-> cs_n && !req_ready)
        else $error("select low in retention");
    AST_RECOVERY: assert property ($fell(cs_n) |-> rcv_q >= RECOV_CYCLES)
        else $error("access before recovery time");
    AST_READ_ANSWER: assert property ($fell(cs_n) && we_n |-> ##6 rsp_valid)
        else $error("read answer late or missing");
endmodule
bind asr_ctrl asr_ctrl_checker #(.RECOV_CYCLES(RECOV_CYCLES)) u_asr_chk (.sys_clk, .rstn,
    .req_ready, .rsp_valid, .retained, .address_lines, .cs_n, .we_n, .oe_n,
    .shared_data_lines_o, .shared_data_lines_oe);

//--- dv/asr_sram_model.sv
`timescale 1ns/100ps
module asr_sram_model (
    // Memory pins
    input wire logic [asr_pkg::ADDR_W-1:0] address_lines,
    input wire logic                       cs_n,
    input wire logic                       we_n,
    input wire logic                       oe_n,
    input wire logic [asr_pkg::DATA_W-1:0] data_in,
    // Memory side of the data lines
    output logic     [asr_pkg::DATA_W-1:0] data_out,
    output logic                           mem_drive
);
    logic [asr_pkg::DATA_W-1:0] mem [0:32767];
    logic [asr_pkg::DATA_W-1:0] dout = 8'h00;
    logic                       rd_en;
    logic                       wr_en;
    assign rd_en = !cs_n && we_n && !oe_n;
    assign wr_en = !cs_n && !we_n;
    // Floating lines show the inverse value so a stale byte never passes
    assign data_out = mem_drive ? dout : ~dout;
    initial mem_drive = 1'b0;
    always @(negedge wr_en) mem[address_lines] = data_in;
    always @(address_lines or posedge rd_en) begin
        dout <= #10 ~dout;
        dout <= #70 mem[address_lines];
    end
    // Turn-on at the least delay, turn-off late: no kinder than a real part
    always @(rd_en) begin
        if (rd_en) #10 mem_drive = rd_en;
        else #30 mem_drive = rd_en;
    end
endmodule

//--- dv/async_sram_rw_port_tb_top.sv
`timescale 1ns/100ps
module async_sram_rw_port_tb_top;
    typedef struct packed {
        logic                       wr;
        logic [asr_pkg::ADDR_W-1:0] addr;
        logic [asr_pkg::DATA_W-1:0] data;
    } asr_row_t;
    localparam int RCV = 20;
    logic sys_clk, rstn, req_valid, req_write, req_ready, rsp_valid;
    logic retain_req, supply_ok, retained, cs_n, we_n, oe_n, shared_data_lines_oe, mem_drive;
    logic [asr_pkg::ADDR_W-1:0] req_addr, address_lines;
    logic [asr_pkg::DATA_W-1:0] req_wdata, rsp_rdata, shared_data_lines_o;
    logic [asr_pkg::DATA_W-1:0] shared_data_lines_i, mem_out;
    int err_count = 0;
    int tests_run = 0;
    int n;
    asr_row_t rows [6] = '{'{1'b1, 15'h0000, 8'ha5}, '{1'b1, 15'h7fff, 8'h5a},
        '{1'b0, 15'h0000, 8'ha5}, '{1'b0, 15'h7fff, 8'h5a},
        '{1'b1, 15'h0000, 8'h3c}, '{1'b0, 15'h0000, 8'h3c}};
    assign shared_data_lines_i = shared_data_lines_oe ? shared_data_lines_o : mem_out;
    asr_ctrl #(.RECOV_CYCLES(RCV)) u_dut (.sys_clk, .rstn, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .retain_req, .supply_ok, .retained,
        .address_lines, .cs_n, .we_n, .oe_n, .shared_data_lines_o, .shared_data_lines_oe,
        .shared_data_lines_i);
    asr_sram_model u_mem (.address_lines, .cs_n, .we_n, .oe_n,
        .data_in(shared_data_lines_i), .data_out(mem_out), .mem_drive);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wait_ready;
        int k;
        for (k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge sys_clk);
        if (k == 400) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic access(input asr_row_t r);
        int k;
        wait_ready();
        req_write = r.wr;
        req_addr = r.addr;
        req_wdata = r.data;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (k = 0; k < 20 && !r.wr && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
        if (!r.wr && k == 20) begin
            err_count++;
            complete_run();
        end
        if (!r.wr) check_byte(rsp_rdata, r.data);
    endtask
    always #10 sys_clk = ~sys_clk;
    // Bus clash watch: both sides driving at a sampling edge
    always @(posedge sys_clk) begin
        if (rstn === 1'b1) check_bit(shared_data_lines_oe & mem_drive, 1'b0);
    end
    initial begin
        {sys_clk, rstn, req_valid, req_write, retain_req} = 5'h00;
        {req_addr, req_wdata, supply_ok} = 24'h000001;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        foreach (rows[i]) access(rows[i]);
        $display("table of accesses done");
        wait_ready();
        retain_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        check_bit(retained & cs_n & !req_ready, 1'b1);
        supply_ok = 1'b0;
        repeat (5) @(negedge sys_clk);
        supply_ok = 1'b1;
        retain_req = 1'b0;
        repeat (6) @(negedge sys_clk);
        check_bit(retained | req_ready | !cs_n, 1'b0);
        supply_ok = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_bit(retained & cs_n, 1'b1);
        supply_ok = 1'b1;
        for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge sys_clk);
        check_bit(n >= RCV && n < 200, 1'b1);
        if (n == 200) complete_run();
        access(rows[5]);
        $display("retention test done");
        wait_ready();
        {req_write, req_addr, req_wdata, req_valid} = 25'h1_0001_77 | 25'h1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        @(negedge sys_clk);
        rstn = 1'b0;
        #1;
        check_bit(cs_n & we_n & oe_n & !shared_data_lines_oe & !req_ready, 1'b1);
        @(negedge sys_clk);
        rstn = 1'b1;
        access(rows[3]);
        $display("reset during write test done");
        complete_run();
    end
endmodule

//--- logic/asr_ctrl.sv
`timescale 1ns/100ps
// How it works
// RL1: Memory writes only while select and write enable overlap low.
// RL2: Memory floats its data pins whenever write enable is low.
// RL3: Selected, write enable high, output enable low: memory drives read data.
// RL4: Output enable stays high throughout every write cycle.
// RL5: Select falling with or after write enable keeps memory outputs off.
// RL6: Address changes only while select and write enable are both high.
// RL7: Write enable stays high for the whole read cycle.
// RL8: We drive data lines only after memory outputs have had time to float.
// RL9: Memory holds old read data 10 ns after address change.
// RL10: Memory drives no sooner than 10 ns after select asserts.
// RL11: Memory drives no sooner than 5 ns after output enable asserts.
// RL12: Memory floats within 30 ns of output enable or select release.
// RL13: Address is valid at least 50 ns before write window ends.
// RL14: Write data valid 30 ns before window end, zero hold allowed.
// RL15: Memory floats within 30 ns of write enable falling.
// RL16: Memory drives again no sooner than 10 ns after write window.
// RL17: Retention entered by raising select, held high throughout.
// RL18: Wait 5 ms after supply returns before any access.
// RL19: During retention only select is held; other pins may float.
// RL20: Read data valid 70 ns after address and select; sampled later.
// RL21: Consecutive accesses spaced at least the 70 ns cycle time.
module asr_ctrl #(
    parameter int RECOV_CYCLES = asr_pkg::RECOV_CYC
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    // User request
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [asr_pkg::DATA_W-1:0]      rsp_rdata,
    // Retention control
    input  wire logic                       retain_req,
    input  wire logic                       supply_ok,
    output logic                            retained,
    // Memory pins
    output logic [asr_pkg::ADDR_W-1:0]      address_lines,
    output logic                            cs_n,
    output logic                            we_n,
    output logic                            oe_n,
    output logic [asr_pkg::DATA_W-1:0]      shared_data_lines_o,
    output logic                            shared_data_lines_oe,
    input  wire logic [asr_pkg::DATA_W-1:0] shared_data_lines_i
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [asr_pkg::DATA_W-1:0] din_s1_q, din_s2_q;
    logic                       sup_s1_q, sup_s2_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            din_s1_q <= shared_data_lines_i;
            din_s2_q <= din_s1_q;
            sup_s1_q <= supply_ok;
            sup_s2_q <= sup_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // State and timer
    // ---------------------------------------------------------------
    asr_pkg::asr_state_t state_q, state_d;
    logic                     tmr_load;
    logic [asr_pkg::RCV_W-1:0] tmr_val;
    logic                     tmr_done;

    asr_delay_cnt #(.W(asr_pkg::RCV_W)) u_tmr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (tmr_load),
        .value   (tmr_val),
        .done    (tmr_done)
    );

    localparam logic [asr_pkg::RCV_W-1:0] RD_LD    = asr_pkg::RCV_W'(asr_pkg::RD_CYC - 1);
    localparam logic [asr_pkg::RCV_W-1:0] WP_LD    = asr_pkg::RCV_W'(asr_pkg::WP_CYC - 1);
    localparam logic [asr_pkg::RCV_W-1:0] TURN_LD  = asr_pkg::RCV_W'(asr_pkg::TURN_CYC - 1);
    localparam logic [asr_pkg::RCV_W-1:0] RECOV_LD = asr_pkg::RCV_W'(RECOV_CYCLES - 1);

    wire start     = (state_q == asr_pkg::ST_IDLE) && req_valid && !retain_req && sup_s2_q;
    wire go_retain = (state_q == asr_pkg::ST_IDLE) && retain_req;

    // Next-state decode
    always_comb begin
        state_d  = state_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        case (state_q)
            asr_pkg::ST_IDLE: begin
                if (go_retain) begin
                    state_d = asr_pkg::ST_RETAIN;
                end else if (start && req_write) begin
                    state_d  = asr_pkg::ST_WR;
                    tmr_load = 1'b1;
                    tmr_val  = WP_LD;
                end else if (start) begin
                    state_d  = asr_pkg::ST_RD;
                    tmr_load = 1'b1;
                    tmr_val  = RD_LD;
                end
            end
            asr_pkg::ST_RD: begin
                if (tmr_done) begin
                    state_d  = asr_pkg::ST_RD_END;
                    tmr_load = 1'b1;
                    tmr_val  = TURN_LD;
                end
            end
            asr_pkg::ST_RD_END: begin
                // Let memory outputs float before the bus may be driven again
                if (tmr_done) begin
                    state_d = asr_pkg::ST_IDLE; // RL8 RL12
                end
            end
            asr_pkg::ST_WR: begin
                if (tmr_done) begin
                    state_d = asr_pkg::ST_WR_END;
                end
            end
            asr_pkg::ST_WR_END: begin
                state_d = asr_pkg::ST_GAP;
            end
            asr_pkg::ST_GAP: begin
                state_d = asr_pkg::ST_IDLE; // RL21
            end
            asr_pkg::ST_RETAIN: begin // RL19
                if (!retain_req && sup_s2_q) begin
                    state_d  = asr_pkg::ST_RECOV;
                    tmr_load = 1'b1;
                    tmr_val  = RECOV_LD;
                end
            end
            asr_pkg::ST_RECOV: begin
                if (!sup_s2_q) begin
                    state_d = asr_pkg::ST_RETAIN;
                end else if (tmr_done) begin
                    state_d = asr_pkg::ST_IDLE; // RL18
                end
            end
            default: begin
                state_d = asr_pkg::ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Pin decode
    // ---------------------------------------------------------------
    wire in_rd    = (state_q == asr_pkg::ST_RD);
    wire in_wr    = (state_q == asr_pkg::ST_WR);
    // Select and write enable fall together so memory never drives
    wire cs_n_d   = !(in_rd || in_wr);                 // RL5 RL17
    wire we_n_d   = !in_wr;                            // RL1 RL7
    wire oe_n_d   = !in_rd;                            // RL4
    wire dq_oe_d  = in_wr || (state_q == asr_pkg::ST_WR_END); // RL8 RL14
    // Taken at the end of turnaround: the synchroniser lags the pins by two edges,
    // so sampling at the end of the read would see data before the access time
    wire rd_last  = (state_q == asr_pkg::ST_RD_END) && tmr_done; // RL20
    wire sp_idle  = (state_q == asr_pkg::ST_IDLE) && !go_retain;
    wire ready_d  = (state_d == asr_pkg::ST_IDLE) && sup_s2_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= asr_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Address and data latch only when a cycle starts, strobes are high then
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            address_lines       <= '0;
            shared_data_lines_o <= '0;
        end else if (start) begin
            address_lines       <= req_addr;  // RL6 RL13
            shared_data_lines_o <= req_wdata; // RL14
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_n                 <= 1'b1;
            we_n                 <= 1'b1;
            oe_n                 <= 1'b1;
            shared_data_lines_oe <= 1'b0;
        end else begin
            cs_n                 <= cs_n_d;
            we_n                 <= we_n_d;
            oe_n                 <= oe_n_d;
            shared_data_lines_oe <= dq_oe_d;
        end
    end

    // Read data comes from the synchroniser, never straight from the pins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            req_ready <= 1'b0;
            retained  <= 1'b0;
        end else begin
            rsp_valid <= rd_last;
            if (rd_last) begin
                rsp_rdata <= din_s2_q;
            end
            req_ready <= ready_d && !start && sp_idle;
            retained  <= (state_d == asr_pkg::ST_RETAIN);
        end
    end

endmodule

//--- logic/asr_delay_cnt.sv
`timescale 1ns/100ps
// Down counter: load a count, done when it has reached zero.
module asr_delay_cnt #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // Status
    output logic              done
);

    logic [W-1:0] cnt_q;

    assign done = (cnt_q == '0);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (!done) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

//--- logic/asr_pkg.sv
package asr_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // ---------------------------------------------------------------
    // Timing, 70 ns grade, at a 50 MHz system clock
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_HZ        = 50_000_000;

    localparam int T_CYCLE_NS    = 70;  // read and write cycle time
    localparam int T_ACCESS_NS   = 70;  // address and select access
    localparam int T_WP_NS       = 55;  // write pulse width
    localparam int T_CW_NS       = 50;  // select to end of write
    localparam int T_AW_NS       = 50;  // address valid to end of write
    localparam int T_DW_NS       = 30;  // data valid to end of write
    localparam int T_HZ_NS       = 30;  // release of memory outputs
    localparam int T_RECOV_MS    = 5;   // retention_recovery_delay

    // Least times round up to whole cycles, plus one more cycle for the read
    localparam int RD_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WP_CYC    = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC  = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CYC   = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CYC = T_RECOV_MS * (CLK_HZ / 1000);

    localparam int CNT_W   = 8;
    localparam int RCV_W   = 24;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RD     = 3'b001,
        ST_RD_END = 3'b010,
        ST_WR     = 3'b011,
        ST_WR_END = 3'b100,
        ST_RETAIN = 3'b101,
        ST_RECOV  = 3'b110,
        ST_GAP    = 3'b111
    } asr_state_t;

endpackage
